// ==== src/dbps_top.sv ====
// Dual-phase buck PWM sequencer: clocking, lockout, sequencing, reset output.
`timescale 1ns/1ps
`default_nettype none
`include "dbps_defs.svh"
module dbps_top
  import dbps_pkg::*;
#(
  parameter int PERIOD_CYC    = 500,
  parameter int MAXDUTY_CYC   = `DBPS_MAXDUTY_CYC,
  parameter int SS_CYC        = `DBPS_SS_CYC,
  parameter int RST_DELAY_CYC = `DBPS_RST_DELAY_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_sync_clk,
  input  wire logic i_sync_sel,
  input  wire logic i_enable,
  input  wire logic i_rail_below_lockout,
  input  wire logic i_rail_below_release,
  input  wire logic i_ch1_pwm_end,
  input  wire logic i_ch2_pwm_end,
  input  wire logic i_ch1_valley_limit,
  input  wire logic i_ch2_valley_limit,
  input  wire logic i_ch1_output_good,
  input  wire logic i_ch2_output_good,
  input  wire logic i_ch1_output_discharged,
  input  wire logic i_ch2_output_discharged,
  input  wire logic i_ch1_low_sensed_off,
  input  wire logic i_ch2_low_sensed_off,
  output logic      o_ch1_high_gate_drive,
  output logic      o_ch1_low_gate_drive,
  output logic      o_ch2_high_gate_drive,
  output logic      o_ch2_low_gate_drive,
  output logic      o_reset_out_n,
  output logic      o_ch1_soft_start_ramp,
  output logic      o_ch2_soft_start_ramp,
  output logic      o_supply_lockout,
  output logic      o_sw_clk
);
  localparam int NS = 13;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  // Synchronized copies of every pin-level input.
  logic s_sync_clk;
  logic s_sync_sel;
  logic s_en;
  logic s_uv;
  logic s_rel;
  logic s_pe1;
  logic s_pe2;
  logic s_vl1;
  logic s_vl2;
  logic s_og1;
  logic s_og2;
  logic s_dis1;
  logic s_dis2;
  logic s_lso1;
  logic s_lso2;

  // All pin-level indications go through two flops first.
  assign raw_in = {i_sync_clk, i_sync_sel, i_enable, i_rail_below_lockout,
                   i_rail_below_release, i_ch1_pwm_end, i_ch2_pwm_end,
                   i_ch1_valley_limit, i_ch2_valley_limit,
                   i_ch1_output_good, i_ch2_output_good,
                   i_ch1_output_discharged, i_ch2_output_discharged};

  dbps_sync #(.W(NS)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (raw_in),
    .o_sync    (syn)
  );

  dbps_sync #(.W(2)) u_sync_lso (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_ch1_low_sensed_off, i_ch2_low_sensed_off}),
    .o_sync    ({s_lso1, s_lso2})
  );

  assign {s_sync_clk, s_sync_sel, s_en, s_uv, s_rel, s_pe1, s_pe2,
          s_vl1, s_vl2, s_og1, s_og2, s_dis1, s_dis2} = syn;

  // Oscillator source: internal divider or the synchronized external clock.
  // A synchronized external edge replaces the tick when it is selected.
  logic [15:0] osc_cnt_ff;
  logic        ext_d_ff;
  logic        osc_tick;
  logic        ext_tick;
  logic        src_tick;
  logic        half;
  assign half = (osc_cnt_ff == 16'(PERIOD_CYC / 2 - 1));
  assign osc_tick = half;
  assign ext_tick = s_sync_clk && !ext_d_ff;
  assign src_tick = s_sync_sel ? ext_tick : osc_tick;

  // Period counter restarts on every switching clock edge, rise and fall, for max duty.
  logic        sw_ff;
  logic [15:0] per_cnt_ff;
  logic [15:0] half_len_ff;
  logic        rise;
  logic        fall;
  logic        max1;
  logic        max2;
  assign rise = src_tick && !sw_ff;
  assign fall = src_tick && sw_ff;
  // Each high side is cut a fixed count before its own half-period ends.
  // Channel one owns the high half of the switching clock and channel two
  // the low half; the edge that closes a half also ends a running pulse.
  assign max1 = sw_ff && ((per_cnt_ff + 16'(MAXDUTY_CYC)) >= half_len_ff)
                || fall;
  assign max2 = !sw_ff && ((per_cnt_ff + 16'(MAXDUTY_CYC)) >= half_len_ff)
                || rise;

  // Divider, switching clock toggle and the captured length of each half.
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      osc_cnt_ff  <= 16'h0000;
      ext_d_ff    <= 1'b0;
      sw_ff       <= 1'b0;
      per_cnt_ff  <= 16'h0000;
      half_len_ff <= 16'hFFFF;
    end
    else
    begin
      osc_cnt_ff <= half ? 16'h0000 : osc_cnt_ff + 16'h0001;
      ext_d_ff   <= s_sync_clk;
      if (src_tick)
      begin
        sw_ff       <= !sw_ff;
        per_cnt_ff  <= 16'h0000;
        half_len_ff <= per_cnt_ff + 16'h0001;
      end
      else
        per_cnt_ff <= per_cnt_ff + 16'h0001;
    end
  end

  // Lockout latch: set below lockout, cleared only below release level.
  // The trip wins over the release when both are seen in one cycle.
  logic uv_latch_ff;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      uv_latch_ff <= 1'b1;
    else if (s_uv)
      uv_latch_ff <= 1'b1;
    else if (s_rel)
      uv_latch_ff <= 1'b0;
  end
  logic lockout;
  assign lockout = uv_latch_ff || s_uv;

  // Power sequencing state machine with soft-start and soft-stop timers.
  dbps_seq_e   st_ff;
  dbps_seq_e   nxt_st;
  logic [31:0] ss_cnt_ff;
  logic        ss_done;
  logic        was_run_ff;
  // One timer measures every soft-start and soft-stop state.
  assign ss_done = (ss_cnt_ff == 32'(SS_CYC - 1));

  // Next-state decode of the power sequencer.
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      // Channel one only, and after prior enable use only once discharged.
      DBPS_OFF:    if (s_en && (!was_run_ff || s_dis1))
                     nxt_st = DBPS_SS1;
      DBPS_SS1:    if (!s_en) nxt_st = DBPS_STOP1;
                   else if (ss_done) nxt_st = DBPS_SS2;
      DBPS_SS2:    if (!s_en) nxt_st = DBPS_STOP2;
                   else if (ss_done) nxt_st = DBPS_RUN;
      DBPS_RUN:    if (!s_en) nxt_st = DBPS_STOP2;
      DBPS_STOP2:  if (ss_done) nxt_st = DBPS_STOP1;
      DBPS_STOP1:  if (ss_done) nxt_st = DBPS_PARKED;
      DBPS_PARKED: if (s_en) nxt_st = DBPS_OFF;
      default:     nxt_st = DBPS_OFF;
    endcase
  end

  // Lockout overrides every state and forgets an earlier enable cycle.
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_ff      <= DBPS_OFF;
      ss_cnt_ff  <= 32'h0000_0000;
      was_run_ff <= 1'b0;
    end
    else if (lockout)
    begin
      st_ff      <= DBPS_OFF;
      ss_cnt_ff  <= 32'h0000_0000;
      was_run_ff <= 1'b0;
    end
    else
    begin
      st_ff     <= nxt_st;
      ss_cnt_ff <= (nxt_st != st_ff) ? 32'h0000_0000 : ss_cnt_ff + 32'h1;
      if (st_ff == DBPS_PARKED)
        was_run_ff <= 1'b1;
    end
  end

  // Channel run and park decodes; disabled enable shuts both down.
  // Soft-stop keeps a channel switching until its own stop state ends.
  logic run1;
  logic run2;
  logic park;
  assign run1 = s_en && (st_ff == DBPS_SS1 || st_ff == DBPS_SS2 ||
                st_ff == DBPS_RUN) || st_ff == DBPS_STOP2
                || st_ff == DBPS_STOP1;
  assign run2 = (s_en && (st_ff == DBPS_SS2 || st_ff == DBPS_RUN))
                || st_ff == DBPS_STOP2;
  assign park = (st_ff == DBPS_PARKED);

  // Channel one starts on the rising switching edge, two on the falling.
  dbps_phase #(.DEAD_CYC(`DBPS_DEAD_CYC)) u_ph1 (
    .i_ref_clk        (i_ref_clk),
    .i_reset_n        (i_reset_n),
    .i_start          (rise),
    .i_max_duty       (max1),
    .i_pwm_end        (s_pe1),
    .i_valley_limit   (s_vl1),
    .i_run            (run1),
    .i_park_low       (park),
    .i_lockout        (lockout),
    .i_low_sensed_off (s_lso1),
    .o_high_gate      (o_ch1_high_gate_drive),
    .o_low_gate       (o_ch1_low_gate_drive),
    .o_high_fall      ()
  );

  dbps_phase #(.DEAD_CYC(`DBPS_DEAD_CYC)) u_ph2 (
    .i_ref_clk        (i_ref_clk),
    .i_reset_n        (i_reset_n),
    .i_start          (fall),
    .i_max_duty       (max2),
    .i_pwm_end        (s_pe2),
    .i_valley_limit   (s_vl2),
    .i_run            (run2),
    .i_park_low       (park),
    .i_lockout        (lockout),
    .i_low_sensed_off (s_lso2),
    .o_high_gate      (o_ch2_high_gate_drive),
    .o_low_gate       (o_ch2_low_gate_drive),
    .o_high_fall      ()
  );

  // Reset output delay after both soft-starts and both outputs good.
  logic [31:0] rst_cnt_ff;
  logic        rst_ok_ff;
  logic        good;
  // Any loss of regulation or a lockout restarts the whole delay.
  assign good = (st_ff == DBPS_RUN) && s_og1 && s_og2 && !lockout;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_cnt_ff <= 32'h0000_0000;
      rst_ok_ff  <= 1'b0;
    end
    else if (!good)
    begin
      rst_cnt_ff <= 32'h0000_0000;
      rst_ok_ff  <= 1'b0;
    end
    else if (rst_cnt_ff == 32'(RST_DELAY_CYC - 1))
      rst_ok_ff <= 1'b1;
    else
      rst_cnt_ff <= rst_cnt_ff + 32'h1;
  end

  // Status flops for the observation outputs.
  // They trail the sequencer state and the lockout by one clock.
  logic ss1_ff;
  logic ss2_ff;
  logic lo_ff;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ss1_ff <= 1'b0;
      ss2_ff <= 1'b0;
      lo_ff  <= 1'b1;
    end
    else
    begin
      ss1_ff <= (st_ff == DBPS_SS1);
      ss2_ff <= (st_ff == DBPS_SS2);
      lo_ff  <= lockout;
    end
  end

  assign o_reset_out_n         = rst_ok_ff;
  assign o_ch1_soft_start_ramp = ss1_ff;
  assign o_ch2_soft_start_ramp = ss2_ff;
  assign o_supply_lockout      = lo_ff;
  assign o_sw_clk              = sw_ff;
endmodule : dbps_top
`default_nettype wire

// ==== common/dbps_defs.svh ====
// Timing constants and the behaviour summary of the dual-phase sequencer.
// Behaviour
// - Switching clock is the selected source divided by two.
// - Channel one pulse starts on clock rise, ends on PWM or max duty.
// - Channel two high side starts on switching clock falling edge.
// - After the high-side pulse ends, high side off and low side on.
// - Valley limit at the edge skips the pulse; low side stays on.
// - Supply lockout holds all four gate drives low.
// - Enable is active high; low shuts down both channels.
// - Rail below lockout threshold disables both channels.
// - Lockout stays latched until rail falls below the release level.
// - Enable high starts channel one only; channel two stays off during channel one soft-start.
// - Leaving lockout with enable high restarts with channel one first.
// - After enable cycling, channel one restarts only once discharged.
// - After lockout, low side stays low until first high-side fall.
// - After soft-stop completes, low side drives are held high.
// - Channel two soft-start begins after channel one soft-start ends.
// - Soft-stop shuts channels down last-on first-off.
// - Low side complements high side, with dead time and off sensing.
// - Reset output low until soft-starts end, outputs good, delay done.
`ifndef DBPS_DEFS_SVH
`define DBPS_DEFS_SVH
`define DBPS_CLK_MHZ        100
`define DBPS_DEAD_NS        30
`define DBPS_DEAD_CYC       ((`DBPS_DEAD_NS * `DBPS_CLK_MHZ + 999) / 1000)
`define DBPS_RST_DELAY_MS   140
`define DBPS_RST_DELAY_CYC  (`DBPS_RST_DELAY_MS * 1000 * `DBPS_CLK_MHZ)
`define DBPS_MAXDUTY_CYC    8
`define DBPS_SS_CYC         4096
`endif

// ==== common/dbps_pkg.sv ====
// Types shared by the dual-phase sequencer.
package dbps_pkg;
  typedef enum logic [2:0] {
    DBPS_OFF    = 3'b000,
    DBPS_SS1    = 3'b001,
    DBPS_SS2    = 3'b011,
    DBPS_RUN    = 3'b010,
    DBPS_STOP2  = 3'b110,
    DBPS_STOP1  = 3'b111,
    DBPS_PARKED = 3'b101
  } dbps_seq_e;
endpackage : dbps_pkg

// ==== src/dbps_sync.sv ====
// Two-flop synchronizer for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module dbps_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second stage.
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule : dbps_sync
`default_nettype wire

// ==== src/dbps_phase.sv ====
// One channel's pulse timing, skip, and dead-time driver logic.
`timescale 1ns/1ps
`default_nettype none
module dbps_phase #(
  parameter int DEAD_CYC = 3
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_start,
  input  wire logic i_max_duty,
  input  wire logic i_pwm_end,
  input  wire logic i_valley_limit,
  input  wire logic i_run,
  input  wire logic i_park_low,
  input  wire logic i_lockout,
  input  wire logic i_low_sensed_off,
  output logic      o_high_gate,
  output logic      o_low_gate,
  output logic      o_high_fall
);
  logic       pulse_ff;
  logic       hi_ff;
  logic       lo_ff;
  logic       hold_low_ff;
  logic [7:0] dead_ff;
  logic       nxt_pulse;
  logic       pulse_on;
  logic       want_low;

  // Pulse starts at the edge unless limited, ends on PWM or max duty.
  assign pulse_on = i_start && i_run && !i_valley_limit;
  assign nxt_pulse = pulse_on ? 1'b1 :
                     ((i_pwm_end || i_max_duty) ? 1'b0 : pulse_ff);
  assign o_high_fall = hi_ff && !(pulse_ff && i_run && !i_lockout);
  // Low side is the complement once the dead time after DH off elapses.
  assign want_low = !pulse_ff && (i_run || i_park_low)
                    && !hold_low_ff && (dead_ff == 8'h00);

  // Pulse flag, gate drives and the post-lockout low-side latch.
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pulse_ff    <= 1'b0;
      hi_ff       <= 1'b0;
      lo_ff       <= 1'b0;
      hold_low_ff <= 1'b1;
      dead_ff     <= 8'h00;
    end
    else if (i_lockout)
    begin
      pulse_ff    <= 1'b0;
      hi_ff       <= 1'b0;
      lo_ff       <= 1'b0;
      hold_low_ff <= 1'b1;
      dead_ff     <= 8'h00;
    end
    else
    begin
      pulse_ff <= nxt_pulse && i_run;
      // High side waits until the low side reads fully off.
      hi_ff <= pulse_ff && i_run && !lo_ff && i_low_sensed_off;
      if (o_high_fall)
      begin
        hold_low_ff <= 1'b0;
        dead_ff     <= 8'(DEAD_CYC);
      end
      else if (dead_ff != 8'h00)
        dead_ff <= dead_ff - 8'h01;
      lo_ff <= want_low && !hi_ff;
    end
  end

  assign o_high_gate = hi_ff;
  assign o_low_gate  = lo_ff;
endmodule : dbps_phase
`default_nettype wire

// ==== verification/dbps_checker.sv ====
// Assertion checker for the dual-phase sequencer top ports.
`timescale 1ns/1ps
`default_nettype none
module dbps_checker (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_rail_below_lockout,
  input wire logic i_ch1_output_good,
  input wire logic o_ch1_high_gate_drive,
  input wire logic o_ch1_low_gate_drive,
  input wire logic o_ch2_high_gate_drive,
  input wire logic o_ch2_low_gate_drive,
  input wire logic o_reset_out_n,
  input wire logic o_ch1_soft_start_ramp,
  input wire logic o_supply_lockout,
  input wire logic o_sw_clk
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  logic wait_fall_ff;
  // Set by lockout, cleared by the first channel one high-side fall.
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
    if (!i_reset_n) wait_fall_ff <= 1'b1;
    else if (o_supply_lockout) wait_fall_ff <= 1'b1;
    else if ($fell(o_ch1_high_gate_drive)) wait_fall_ff <= 1'b0;
  // Gate, lockout and reset-output relations that must hold in every state.
  property p_lock_gates;
    o_supply_lockout |=> !(o_ch1_high_gate_drive | o_ch1_low_gate_drive
      | o_ch2_high_gate_drive | o_ch2_low_gate_drive);
  endproperty
  a_lock_gates: assert property (p_lock_gates)
    else $error("gate on in lockout");
  property p_no_ovl1; !(o_ch1_high_gate_drive && o_ch1_low_gate_drive);
  endproperty
  a_no_ovl1: assert property (p_no_ovl1)
    else $error("ch1 shoot-through");
  property p_no_ovl2; !(o_ch2_high_gate_drive && o_ch2_low_gate_drive);
  endproperty
  a_no_ovl2: assert property (p_no_ovl2)
    else $error("ch2 shoot-through");
  property p_dead1;
    $fell(o_ch1_high_gate_drive) |-> !o_ch1_low_gate_drive [*3];
  endproperty
  a_dead1: assert property (p_dead1)
    else $error("ch1 dead time short");
  property p_ch2_idle;
    o_ch1_soft_start_ramp |-> !o_ch2_high_gate_drive && !o_ch2_low_gate_drive;
  endproperty
  a_ch2_idle: assert property (p_ch2_idle)
    else $error("ch2 active in ch1 soft-start");
  property p_ch1_half; o_ch1_high_gate_drive |-> o_sw_clk; endproperty
  a_ch1_half: assert property (p_ch1_half)
    else $error("ch1 pulse outside high half");
  property p_ch2_half; o_ch2_high_gate_drive |-> !o_sw_clk; endproperty
  a_ch2_half: assert property (p_ch2_half)
    else $error("ch2 pulse outside low half");
  property p_lock_trip;
    $rose(i_rail_below_lockout) |-> ##[1:4] o_supply_lockout;
  endproperty
  a_lock_trip: assert property (p_lock_trip)
    else $error("lockout not entered");
  property p_rst_good;
    $fell(i_ch1_output_good) |-> ##[1:5] !o_reset_out_n;
  endproperty
  a_rst_good: assert property (p_rst_good)
    else $error("reset output stayed high");
  property p_dl_latch; wait_fall_ff |-> !o_ch1_low_gate_drive; endproperty
  a_dl_latch: assert property (p_dl_latch)
    else $error("ch1 low side left latch early");
  // Main scenarios.
  c_ch2_on: cover property ($rose(o_ch2_high_gate_drive));
  c_rst_up: cover property ($rose(o_reset_out_n));
  c_unlock: cover property ($fell(o_supply_lockout));
endmodule : dbps_checker
bind dbps_top dbps_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_rail_below_lockout(i_rail_below_lockout),
  .i_ch1_output_good(i_ch1_output_good),
  .o_ch1_high_gate_drive(o_ch1_high_gate_drive),
  .o_ch1_low_gate_drive(o_ch1_low_gate_drive),
  .o_ch2_high_gate_drive(o_ch2_high_gate_drive),
  .o_ch2_low_gate_drive(o_ch2_low_gate_drive),
  .o_reset_out_n(o_reset_out_n),
  .o_ch1_soft_start_ramp(o_ch1_soft_start_ramp),
  .o_supply_lockout(o_supply_lockout), .o_sw_clk(o_sw_clk)
);
`default_nettype wire

// ==== verification/dbps_fet_model.sv ====
// Behavioural MOSFET pair: low-side off sensing and PWM pulse end.
`timescale 1ns/1ps
`default_nettype none
module dbps_fet_model #(
  parameter int ON_CYC = 12
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_high_gate,
  input  wire logic i_low_gate,
  input  wire logic i_long,
  output logic      o_low_sensed_off,
  output logic      o_pwm_end
);
  logic [1:0] off_ff;
  int         on_cnt;
  // Gate charge needs two cycles to drain before off is sensed.
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
    if (!i_reset_n) off_ff <= 2'h3;
    else off_ff <= {off_ff[0], ~i_low_gate};
  assign o_low_sensed_off = off_ff[1] & ~i_low_gate;
  // Count on-time; a long request never ends the pulse.
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
    if (!i_reset_n) on_cnt <= 0;
    else on_cnt <= i_high_gate ? on_cnt + 1 : 0;
  assign o_pwm_end = i_high_gate & ~i_long & (on_cnt >= ON_CYC);
endmodule : dbps_fet_model
`default_nettype wire

// ==== verification/dbps_top_tb.sv ====
// Self-checking bench for the dual-phase sequencer.
`timescale 1ns/1ps
`default_nettype none
module dbps_top_tb;
  localparam int PER = 40;
  localparam int SS = 64;
  localparam int RDLY = 200;
  logic clk, rst_n, sync_clk, sync_sel, en, blw_lock, blw_rel;
  logic pe1, pe2, vl1, vl2, gd1, gd2, dis1, so1, so2, lg1, lg2;
  logic h1, l1, h2, l2, rst_out_n, ss1, ss2, lock, sw;
  int err_count, comparisons;
  dbps_top #(.PERIOD_CYC(PER), .SS_CYC(SS), .RST_DELAY_CYC(RDLY)) uut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_sync_clk(sync_clk),
    .i_sync_sel(sync_sel), .i_enable(en), .i_rail_below_lockout(blw_lock),
    .i_rail_below_release(blw_rel), .i_ch1_pwm_end(pe1),
    .i_ch2_pwm_end(pe2), .i_ch1_valley_limit(vl1),
    .i_ch2_valley_limit(vl2), .i_ch1_output_good(gd1),
    .i_ch2_output_good(gd2), .i_ch1_output_discharged(dis1),
    .i_ch2_output_discharged(1'b1), .i_ch1_low_sensed_off(so1),
    .i_ch2_low_sensed_off(so2), .o_ch1_high_gate_drive(h1),
    .o_ch1_low_gate_drive(l1), .o_ch2_high_gate_drive(h2),
    .o_ch2_low_gate_drive(l2), .o_reset_out_n(rst_out_n),
    .o_ch1_soft_start_ramp(ss1), .o_ch2_soft_start_ramp(ss2),
    .o_supply_lockout(lock), .o_sw_clk(sw));
  // Channel one's comparator ends a pulse before max duty would.
  dbps_fet_model #(.ON_CYC(2)) m1 (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_high_gate(h1), .i_low_gate(l1), .i_long(lg1),
    .o_low_sensed_off(so1), .o_pwm_end(pe1));
  dbps_fet_model m2 (.i_ref_clk(clk), .i_reset_n(rst_n), .i_high_gate(h2),
    .i_low_gate(l2), .i_long(lg2), .o_low_sensed_off(so2), .o_pwm_end(pe2));
  // Logic clock and a 60-cycle external sync clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    sync_clk = 1'b0;
    forever #300 sync_clk = ~sync_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [15:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k = 0;
    while (s !== v && k < lim)
    begin
      step(1);
      k++;
    end
    if (k >= lim)
    begin
      check(16'h0000, 16'h0001, "wait ran out");
      wrap_up();
    end
  endtask : wait_for
  // Cycles until the signal leaves its present value.
  task automatic run_len(ref logic s, output int c);
    logic v = s;
    c = 0;
    while (s === v && c < 500)
    begin
      step(1);
      c++;
    end
    if (c >= 500)
    begin
      check(16'h0000, 16'h0001, "edge wait ran out");
      wrap_up();
    end
  endtask : run_len
  task automatic count_hi(ref logic s, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      step(1);
      if (s === 1'b1) c++;
    end
  endtask : count_hi
  task automatic t_clock();
    int c;
    run_len(sw, c);
    run_len(sw, c);
    check(16'(c), 16'(PER / 2), "internal half period");
    sync_sel = 1'b1;
    step(200);
    run_len(sw, c);
    run_len(sw, c);
    check(16'(c), 16'h003C, "sync half period");
    sync_sel = 1'b0;
    step(200);
    $display("t_clock done");
  endtask : t_clock
  task automatic t_start();
    int c;
    check(lock, 1'b1, "lockout not latched");
    blw_rel = 1'b1;
    step(5);
    blw_rel = 1'b0;
    step(100);
    check(lock, 1'b0, "lockout stuck");
    check(h1 | l1 | h2 | l2, 1'b0, "switching while disabled");
    en = 1'b1;
    wait_for(ss1, 1'b1, 10);
    count_hi(h2, SS / 2, c);
    check(16'(c), 16'h0000, "ch2 pulsed in ch1 soft-start");
    check(ss2, 1'b0, "ch2 soft-start early");
    wait_for(ss1, 1'b0, SS);
    wait_for(ss2, 1'b1, 5);
    wait_for(ss2, 1'b0, SS + 5);
    run_len(rst_out_n, c);
    check(16'(c >= RDLY - 1 && c < RDLY + 5), 16'h0001,
          "reset release delay");
    $display("t_start done");
  endtask : t_start
  task automatic t_pulse();
    int c;
    int c2;
    lg1 = 1'b1;
    wait_for(h1, 1'b0, PER);
    wait_for(h1, 1'b1, 2 * PER);
    run_len(h1, c);
    check(16'(c <= PER / 2 - 8 && c > 0), 16'h0001, "max duty");
    step(5);
    check(l1, 1'b1, "low side off after pulse");
    lg1 = 1'b0;
    wait_for(h1, 1'b1, 2 * PER);
    run_len(h1, c2);
    check(16'(c2 < c), 16'h0001, "pulse not ended by PWM");
    vl1 = 1'b1;
    vl2 = 1'b1;
    step(5);
    count_hi(h1, 2 * PER, c);
    check(16'(c), 16'h0000, "ch1 pulse not skipped");
    check(l1, 1'b1, "ch1 low side off in skip");
    count_hi(h2, 2 * PER, c);
    check(16'(c), 16'h0000, "ch2 pulse not skipped");
    check(l2, 1'b1, "ch2 low side off in skip");
    vl1 = 1'b0;
    vl2 = 1'b0;
    gd1 = 1'b0;
    step(6);
    check(rst_out_n, 1'b0, "reset kept high");
    gd1 = 1'b1;
    wait_for(rst_out_n, 1'b1, RDLY + 20);
    gd2 = 1'b0;
    step(6);
    check(rst_out_n, 1'b0, "reset kept high by ch2");
    gd2 = 1'b1;
    $display("t_pulse done");
  endtask : t_pulse
  task automatic t_lock();
    blw_lock = 1'b1;
    step(5);
    check({lock, h1, l1, h2, l2, rst_out_n}, 6'h20, "lockout");
    blw_lock = 1'b0;
    step(20);
    check(lock, 1'b1, "latch cleared early");
    blw_rel = 1'b1;
    step(5);
    blw_rel = 1'b0;
    wait_for(ss1, 1'b1, 20);
    check(h2 | l2, 1'b0, "ch2 on at restart");
    wait_for(ss2, 1'b1, SS + 20);
    wait_for(ss2, 1'b0, SS + 5);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_stop();
    int c1;
    int c2;
    en = 1'b0;
    // Look only inside the channel one stop state.
    step(SS + 8);
    c1 = 0;
    c2 = 0;
    repeat (PER)
    begin
      step(1);
      if (h1 === 1'b1) c1++;
      if (h2 === 1'b1) c2++;
    end
    check(16'(c1 > 0), 16'h0001, "ch1 stopped first");
    check(16'(c2), 16'h0000, "ch2 still on");
    step(SS);
    check({h1, l1, h2, l2}, 4'h5, "parked drives");
    dis1 = 1'b0;
    en = 1'b1;
    count_hi(h1, 200, c2);
    check(16'(c2), 16'h0000, "restart before discharge");
    dis1 = 1'b1;
    wait_for(ss1, 1'b1, 20);
    $display("t_stop done");
  endtask : t_stop
  // Main sequence.
  initial
  begin
    err_count = 0;
    comparisons = 0;
    {rst_n, sync_sel, en, blw_lock, blw_rel, vl1, vl2, lg1, lg2} = '0;
    {gd1, gd2, dis1} = 3'h7;
    step(6);
    rst_n = 1'b1;
    step(2);
    t_clock();
    t_start();
    t_pulse();
    t_lock();
    t_stop();
    wrap_up();
  end
endmodule : dbps_top_tb
`default_nettype wire
